// ===== core/counter_array_cfg.svh
`ifndef COUNTER_ARRAY_CFG_SVH
`define COUNTER_ARRAY_CFG_SVH
// Notes on behaviour
// - Counter wrap sets sticky overflow flag.
// - Overflow flag with enable raises request.
// - Counter runs while run bit or watchdog enable set.
// - Control bits five to three read zero.
// - Match or capture sets sticky module flag.
// - Module flag with enable raises request.
// - Idle suspend stops counter during idle.
// - Watchdog enable turns module two watchdog.
// - Lock keeps watchdog enabled until reset.
// - Timebase field selects counter tick source.
// - External edges counted on falling transitions.
// - External clock synchronised, then divided eight.
// - Mode writes under watchdog only clear it, if unlocked.
// - Wide select picks sixteen or eight bit.
// - Comparator enable gates compare function.
// - Capture on rising or falling input edge.
// - Match enable makes equality set flag.
// - Toggle enable inverts pin on match.
// - Pulse width enable drives modulated pin.
// - Toggle plus pulse width gives frequency.
// - Counter readable; writable as bytes while watchdog off.
// - Compare value readable and writable bytes.
// - Low write clears, high write sets comparator.
// - Watchdog enable resets to one.
// - Flag two write forces watchdog reset while watchdog enabled.
`define ADDR_CTRL   8'hd8
`define ADDR_MODE   8'hd9
`define ADDR_MOD0   8'hda
`define ADDR_MOD1   8'hdb
`define ADDR_MOD2   8'hdc
`define ADDR_CNT_LO 8'hf9
`define ADDR_CNT_HI 8'hfa
`define ADDR_CMPH0  8'hfc
`define ADDR_CMPH1  8'he9
`define ADDR_CMPH2  8'hec
`define ADDR_CMPL0  8'hfb
`define ADDR_CMPL1  8'hea
`define ADDR_CMPL2  8'hed
`define RST_CTRL    8'h00
`define RST_MODE    8'h40
`define BIT_OVF     7
`define BIT_RUN     6
`define BIT_IDLE    7
`define BIT_WATCHDOG_ENABLE    6
`define BIT_LOCK    5
`define TB_HI       3
`define TB_LO       1
`define BIT_OVF_IE  0
`define WDT_MODULE  2
`define TB_DIV12    3'h0
`define TB_DIV4     3'h1
`define TB_TIMER0   3'h2
`define TB_EDGE     3'h3
`define TB_SYSCLK   3'h4
`define TB_EXT8     3'h5
`define DIV_SYS12   12
`define DIV_SYS4    4
`define DIV_EXT     8
`endif

// ===== core/counter_array_pkg.sv
package counter_array_pkg;
   typedef struct packed {
      logic wide;
      logic cmp_en;
      logic rise_cap;
      logic fall_cap;
      logic match_en;
      logic toggle_en;
      logic pwm_en;
      logic irq_en;
   } module_mode_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic [7:0] wdata;
   } sfr_req_t;
endpackage

// ===== core/counter_timebase.sv
`timescale 1ns/10ps
`default_nettype none
`include "counter_array_cfg.svh"
module counter_timebase #(
   parameter int DIV12 = `DIV_SYS12,
   parameter int DIV4  = `DIV_SYS4,
   parameter int DIV8  = `DIV_EXT
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Source selection and sources
   input  wire logic [2:0] sel_i,
   input  wire logic       timer0_ovf_i,
   input  wire logic       ext_count_i,
   input  wire logic       ext_osc_i,
   // Counter tick
   output logic            tick_o
);
   logic [3:0] div12, next_div12;
   logic [1:0] div4, next_div4;
   logic [2:0] div8, next_div8;
   logic       cnt_prev, osc_meta, osc_sync, osc_prev, next_tick;
   logic       osc_edge;

   always_comb begin
      next_div12 = (div12 == 4'(DIV12 - 1)) ? 4'h0 : div12 + 4'h1;
      next_div4  = (div4 == 2'(DIV4 - 1)) ? 2'h0 : div4 + 2'h1;
      osc_edge   = osc_sync & ~osc_prev;
      next_div8  = osc_edge ? div8 + 3'h1 : div8;
      unique case (sel_i)
         `TB_DIV12:  next_tick = (div12 == 4'(DIV12 - 1));
         `TB_DIV4:   next_tick = (div4 == 2'(DIV4 - 1));
         `TB_TIMER0: next_tick = timer0_ovf_i;
         `TB_EDGE:   next_tick = cnt_prev & ~ext_count_i;
         `TB_SYSCLK: next_tick = 1'b1;
         `TB_EXT8:   next_tick = osc_edge & (div8 == 3'(DIV8 - 1));
         default:    next_tick = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         div12    <= 4'h0;
         div4     <= 2'h0;
         div8     <= 3'h0;
         cnt_prev <= 1'b1;
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         osc_prev <= 1'b0;
         tick_o   <= 1'b0;
      end else begin
         div12    <= next_div12;
         div4     <= next_div4;
         div8     <= next_div8;
         cnt_prev <= ext_count_i;
         osc_meta <= ext_osc_i;
         osc_sync <= osc_meta;
         osc_prev <= osc_sync;
         tick_o   <= next_tick;
      end
   end
endmodule
`default_nettype wire

// ===== core/counter_capture_module.sv
`timescale 1ns/10ps
`default_nettype none
module counter_capture_module
   import counter_array_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // Configuration
   input  wire module_mode_t mode_i,
   input  wire logic         wdt_mode_i,
   // Counter view
   input  wire logic [15:0]  count_i,
   input  wire logic [15:0]  cnt_next_i,
   input  wire logic         step_i,
   input  wire logic         lo_wrap_i,
   input  wire logic         wrap_i,
   // Register writes
   input  wire logic         wr_low_i,
   input  wire logic         wr_high_i,
   input  wire logic [7:0]   wdata_i,
   // Pins and events
   input  wire logic         cap_pin_i,
   output logic [15:0]       value_o,
   output logic              pin_o,
   output logic              event_o,
   output logic              expire_o
);
   logic [15:0] next_value;
   logic        next_pin, cap_prev, captured, match;
   logic        freq, pwm8, pwm16;

   always_comb begin
      freq  = mode_i.toggle_en & mode_i.pwm_en;
      pwm8  = mode_i.pwm_en & ~mode_i.toggle_en & ~mode_i.wide;
      pwm16 = mode_i.pwm_en & ~mode_i.toggle_en & mode_i.wide;
      captured = ~wdt_mode_i &
         ((mode_i.rise_cap & cap_pin_i & ~cap_prev) |
          (mode_i.fall_cap & ~cap_pin_i & cap_prev));
      match = step_i & mode_i.cmp_en & ~wdt_mode_i &
         ((freq | pwm8) ? (cnt_next_i[7:0] == value_o[7:0]) :
                          (cnt_next_i == value_o));
      event_o  = captured | (match & mode_i.match_en);
      expire_o = wdt_mode_i & lo_wrap_i &
                 (count_i[15:8] == value_o[15:8]);
      next_value = value_o;
      if (wr_low_i)
         next_value[7:0] = wdata_i;
      if (wr_high_i) begin
         next_value[15:8] = wdt_mode_i ?
            count_i[15:8] + value_o[7:0] : wdata_i;
      end else if (captured) begin
         next_value = count_i;
      end else if (freq & match) begin
         next_value[7:0] = value_o[7:0] + value_o[15:8];
      end else if (pwm8 & lo_wrap_i & ~wr_low_i) begin
         next_value[7:0] = value_o[15:8];
      end
      next_pin = pin_o;
      if (!wdt_mode_i) begin
         if (mode_i.pwm_en & ~mode_i.toggle_en & ~mode_i.cmp_en)
            next_pin = 1'b0;
         else if (match & mode_i.toggle_en)
            next_pin = ~pin_o;
         else if ((pwm8 | pwm16) & match)
            next_pin = 1'b1;
         else if ((pwm8 & lo_wrap_i) | (pwm16 & wrap_i))
            next_pin = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         value_o  <= 16'h0000;
         pin_o    <= 1'b0;
         cap_prev <= 1'b0;
      end else begin
         value_o  <= next_value;
         pin_o    <= next_pin;
         cap_prev <= cap_pin_i;
      end
   end
endmodule
`default_nettype wire

// ===== core/counter_array_register_set.sv
`timescale 1ns/10ps
`default_nettype none
`include "counter_array_cfg.svh"
module counter_array_register_set
   import counter_array_pkg::*;
#(
   parameter int MODULES = 3
) (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   // Special function register port
   input  wire sfr_req_t           sfr_i,
   output logic [7:0]              sfr_rdata_o,
   // System inputs
   input  wire logic               cpu_idle_i,
   input  wire logic               timer0_ovf_i,
   input  wire logic               external_count_input_i,
   input  wire logic               ext_osc_i,
   // Module pins
   input  wire logic [MODULES-1:0] capture_pin_i,
   output logic [MODULES-1:0]      module_output_pin_o,
   // Requests
   output logic                    irq_o,
   output logic                    watchdog_reset_o
);
   localparam logic [7:0] CTRL_RESET = `RST_CTRL;
   localparam logic [7:0] MODE_RESET = `RST_MODE;
   localparam logic [7:0] MODE_ADDR [3] =
      '{`ADDR_MOD0, `ADDR_MOD1, `ADDR_MOD2};
   localparam logic [7:0] CMPL_ADDR [3] =
      '{`ADDR_CMPL0, `ADDR_CMPL1, `ADDR_CMPL2};
   localparam logic [7:0] CMPH_ADDR [3] =
      '{`ADDR_CMPH0, `ADDR_CMPH1, `ADDR_CMPH2};

   logic               run, next_run;
   logic               overflow_flag, next_overflow_flag;
   logic [MODULES-1:0] module_match_flag, next_module_match_flag;
   logic               idle_suspend, next_idle_suspend;
   logic               watchdog_enable, next_watchdog_enable;
   logic               watchdog_lock, next_watchdog_lock;
   logic [2:0]         timebase_select, next_timebase_select;
   logic               overflow_irq_enable, next_overflow_irq_enable;
   module_mode_t       module_mode [MODULES];
   module_mode_t       next_module_mode [MODULES];
   logic [15:0]        count, next_count;
   logic [7:0]         next_rdata;
   logic               next_irq, next_wdt_reset;

   logic               tick, counting, step, lo_wrap, wrap;
   logic [15:0]        cnt_next;
   logic               wr_ctrl, wr_mode, wr_lo, wr_hi, force_wdt;
   logic [MODULES-1:0] wr_cmpl, wr_cmph, mod_event, mod_expire;
   logic [15:0]        mod_value [MODULES];

   assign wr_ctrl   = sfr_i.wr & (sfr_i.addr == `ADDR_CTRL);
   assign wr_mode   = sfr_i.wr & (sfr_i.addr == `ADDR_MODE);
   assign wr_lo     = sfr_i.wr & (sfr_i.addr == `ADDR_CNT_LO);
   assign wr_hi     = sfr_i.wr & (sfr_i.addr == `ADDR_CNT_HI);
   assign force_wdt = watchdog_enable & wr_ctrl &
                      sfr_i.wdata[`WDT_MODULE];

   counter_timebase u_timebase (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .sel_i        (timebase_select),
      .timer0_ovf_i (timer0_ovf_i),
      .ext_count_i  (external_count_input_i),
      .ext_osc_i    (ext_osc_i),
      .tick_o       (tick)
   );

   // The counter is forced on while the watchdog runs.
   always_comb begin
      counting = (run | watchdog_enable) &
                 ~(idle_suspend & cpu_idle_i);
      step     = counting & tick;
      cnt_next = count + 16'h0001;
      lo_wrap  = step & (cnt_next[7:0] == 8'h00);
      wrap     = step & (cnt_next == 16'h0000);
   end

   genvar g;
   generate
      for (g = 0; g < MODULES; g++) begin : g_mod
         logic wdt_mode;
         assign wdt_mode = (g == `WDT_MODULE) & watchdog_enable;
         assign wr_cmpl[g] = sfr_i.wr & (sfr_i.addr == CMPL_ADDR[g]);
         assign wr_cmph[g] = sfr_i.wr & (sfr_i.addr == CMPH_ADDR[g]);

         counter_capture_module u_ccm (
            .clk_i      (clk_i),
            .rst_n_i    (rst_n_i),
            .mode_i     (module_mode[g]),
            .wdt_mode_i (wdt_mode),
            .count_i    (count),
            .cnt_next_i (cnt_next),
            .step_i     (step),
            .lo_wrap_i  (lo_wrap),
            .wrap_i     (wrap),
            .wr_low_i   (wr_cmpl[g]),
            .wr_high_i  (wr_cmph[g]),
            .wdata_i    (sfr_i.wdata),
            .cap_pin_i  (capture_pin_i[g]),
            .value_o    (mod_value[g]),
            .pin_o      (module_output_pin_o[g]),
            .event_o    (mod_event[g]),
            .expire_o   (mod_expire[g])
         );

         always_comb begin
            next_module_mode[g] = module_mode[g];
            if (sfr_i.wr && sfr_i.addr == MODE_ADDR[g] && !wdt_mode)
               next_module_mode[g] = module_mode_t'(sfr_i.wdata);
            if (wr_cmpl[g])
               next_module_mode[g].cmp_en = 1'b0;
            if (wr_cmph[g])
               next_module_mode[g].cmp_en = 1'b1;
            // A hardware event wins over a software clear.
            next_module_match_flag[g] = mod_event[g] |
               (wr_ctrl ? sfr_i.wdata[g] : module_match_flag[g]);
         end

         always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
               module_mode[g]       <= module_mode_t'(8'h00);
               module_match_flag[g] <= 1'b0;
            end else begin
               module_mode[g]       <= next_module_mode[g];
               module_match_flag[g] <= next_module_match_flag[g];
            end
         end

         flag_set_a: assert property (@(posedge clk_i)
            disable iff (!rst_n_i)
            mod_event[g] |=> module_match_flag[g])
            else $error("module flag not set by event");
         irq_flag_a: assert property (@(posedge clk_i)
            disable iff (!rst_n_i)
            module_match_flag[g] && module_mode[g].irq_en |=> irq_o)
            else $error("module flag did not raise request");
         cmpl_clear_a: assert property (@(posedge clk_i)
            disable iff (!rst_n_i)
            wr_cmpl[g] && !wr_cmph[g] |=> !module_mode[g].cmp_en)
            else $error("low byte write left comparator on");
      end
   endgenerate

   always_comb begin
      next_run                 = run;
      next_overflow_flag       = wrap | overflow_flag;
      next_idle_suspend        = idle_suspend;
      next_watchdog_enable     = watchdog_enable;
      next_watchdog_lock       = watchdog_lock;
      next_timebase_select     = timebase_select;
      next_overflow_irq_enable = overflow_irq_enable;
      next_count               = step ? cnt_next : count;
      if (wr_ctrl) begin
         next_run           = sfr_i.wdata[`BIT_RUN];
         next_overflow_flag = wrap | sfr_i.wdata[`BIT_OVF];
      end
      if (wr_mode) begin
         if (!watchdog_enable) begin
            next_idle_suspend    = sfr_i.wdata[`BIT_IDLE];
            next_watchdog_lock   = sfr_i.wdata[`BIT_LOCK];
            next_watchdog_enable = sfr_i.wdata[`BIT_WATCHDOG_ENABLE] |
                                   sfr_i.wdata[`BIT_LOCK];
            next_timebase_select = sfr_i.wdata[`TB_HI:`TB_LO];
            next_overflow_irq_enable = sfr_i.wdata[`BIT_OVF_IE];
         end else if (!watchdog_lock && !sfr_i.wdata[`BIT_WATCHDOG_ENABLE] &&
                      !sfr_i.wdata[`BIT_LOCK]) begin
            next_watchdog_enable = 1'b0;
         end
      end
      if (!watchdog_enable) begin
         if (wr_lo)
            next_count[7:0] = sfr_i.wdata;
         if (wr_hi)
            next_count[15:8] = sfr_i.wdata;
      end
      next_irq = (overflow_flag & overflow_irq_enable);
      for (int i = 0; i < MODULES; i++)
         next_irq = next_irq |
            (module_match_flag[i] & module_mode[i].irq_en);
      next_wdt_reset = force_wdt |
         (watchdog_enable & mod_expire[`WDT_MODULE]);
   end

   // Read data follows the address by one clock.
   always_comb begin
      next_rdata = 8'h00;
      if (sfr_i.addr == `ADDR_CTRL) begin
         next_rdata[`BIT_OVF] = overflow_flag;
         next_rdata[`BIT_RUN] = run;
         next_rdata[MODULES-1:0] = module_match_flag;
      end else if (sfr_i.addr == `ADDR_MODE) begin
         next_rdata[`BIT_IDLE]     = idle_suspend;
         next_rdata[`BIT_WATCHDOG_ENABLE]     = watchdog_enable;
         next_rdata[`BIT_LOCK]     = watchdog_lock;
         next_rdata[`TB_HI:`TB_LO] = timebase_select;
         next_rdata[`BIT_OVF_IE]   = overflow_irq_enable;
      end else if (sfr_i.addr == `ADDR_CNT_LO) begin
         next_rdata = count[7:0];
      end else if (sfr_i.addr == `ADDR_CNT_HI) begin
         next_rdata = count[15:8];
      end
      for (int i = 0; i < MODULES; i++) begin
         if (sfr_i.addr == MODE_ADDR[i])
            next_rdata = module_mode[i];
         if (sfr_i.addr == CMPL_ADDR[i])
            next_rdata = mod_value[i][7:0];
         if (sfr_i.addr == CMPH_ADDR[i])
            next_rdata = mod_value[i][15:8];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         run                 <= CTRL_RESET[`BIT_RUN];
         overflow_flag       <= 1'b0;
         idle_suspend        <= 1'b0;
         watchdog_enable     <= MODE_RESET[`BIT_WATCHDOG_ENABLE];
         watchdog_lock       <= 1'b0;
         timebase_select     <= `TB_DIV12;
         overflow_irq_enable <= 1'b0;
         count               <= 16'h0000;
         sfr_rdata_o         <= 8'h00;
         irq_o               <= 1'b0;
         watchdog_reset_o    <= 1'b0;
      end else begin
         run                 <= next_run;
         overflow_flag       <= next_overflow_flag;
         idle_suspend        <= next_idle_suspend;
         watchdog_enable     <= next_watchdog_enable;
         watchdog_lock       <= next_watchdog_lock;
         timebase_select     <= next_timebase_select;
         overflow_irq_enable <= next_overflow_irq_enable;
         count               <= next_count;
         sfr_rdata_o         <= next_rdata;
         irq_o               <= next_irq;
         watchdog_reset_o    <= next_wdt_reset;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   ovf_set_a: assert property (wrap |=> overflow_flag)
      else $error("overflow flag not set on wrap");
   ovf_hold_a: assert property (
      overflow_flag && !wr_ctrl |=> overflow_flag)
      else $error("overflow flag cleared by hardware");
   irq_ovf_a: assert property (
      overflow_flag && overflow_irq_enable |=> irq_o)
      else $error("overflow did not raise request");
   irq_quiet_a: assert property (
      !overflow_irq_enable && module_match_flag == '0 |=> !irq_o)
      else $error("request without enabled flag");
   run_stop_a: assert property (
      !run && !watchdog_enable && !wr_lo && !wr_hi
      |=> count == $past(count))
      else $error("counter moved while stopped");
   rsvd_zero_a: assert property (
      sfr_i.addr == `ADDR_CTRL |=> sfr_rdata_o[5:3] == 3'h0)
      else $error("unused control bits read non-zero");
   idle_hold_a: assert property (
      idle_suspend && cpu_idle_i && !wr_lo && !wr_hi
      |=> count == $past(count))
      else $error("counter moved in suspended idle");
   lock_keep_a: assert property (watchdog_lock |=> watchdog_enable)
      else $error("locked watchdog was disabled");
   mode_frozen_a: assert property (
      watchdog_enable |=> timebase_select == $past(timebase_select)
      && idle_suspend == $past(idle_suspend))
      else $error("mode register changed under watchdog");
   wdt_force_a: assert property (force_wdt |=> watchdog_reset_o)
      else $error("forced watchdog reset missing");
   count_step_a: assert property (
      step && !wr_lo && !wr_hi |=> count == $past(cnt_next))
      else $error("counter did not advance by one");

   wrap_c: cover property (wrap ##1 irq_o);
   wdt_c: cover property (watchdog_enable ##1 watchdog_reset_o);
   event_c: cover property (|mod_event);
   pin_c: cover property ($rose(module_output_pin_o[0]));
endmodule
`default_nettype wire

// ===== verification/pin_side_model.sv
`timescale 1ns/10ps
`default_nettype none
module pin_side_model (
   // Clock and watched pins
   input  wire logic       clk_i,
   input  wire logic [2:0] pin_i,
   // Driven pins
   output logic            count_o,
   output logic            osc_o,
   output logic [2:0]      cap_o
);
   initial begin
      count_o = 1'b1;
      osc_o = 1'b0;
      cap_o = '0;
   end
   // Falling edges eight clocks apart, slower than a quarter clock.
   task automatic edges(input int n);
      repeat (n) begin
         repeat (4) @(negedge clk_i);
         count_o <= 1'b0;
         repeat (4) @(negedge clk_i);
         count_o <= 1'b1;
      end
   endtask
   // The oscillator stands still at zero outside a burst.
   task automatic osc_run(input int n);
      repeat (n) begin
         repeat (2) @(negedge clk_i);
         osc_o <= 1'b1;
         repeat (2) @(negedge clk_i);
         osc_o <= 1'b0;
      end
   endtask
   task automatic set_cap(input int i, input logic v);
      @(negedge clk_i);
      cap_o[i] <= v;
   endtask
   task automatic measure(input int i, n, output int hi, tg);
      logic last;
      hi = 0;
      tg = 0;
      last = pin_i[i];
      repeat (n) begin
         @(negedge clk_i);
         hi += int'(pin_i[i] === 1'b1);
         tg += int'(pin_i[i] !== last);
         last = pin_i[i];
      end
   endtask
endmodule
`default_nettype wire

// ===== verification/counter_array_register_set_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "counter_array_cfg.svh"
module counter_array_register_set_bench;
   import counter_array_pkg::*;
   logic       clk_i = 1'b0;
   logic       rst_n_i = 1'b0;
   sfr_req_t   sfr_i = '0;
   logic       cpu_idle_i = 1'b0;
   logic       timer0_ovf_i = 1'b0;
   logic [7:0] sfr_rdata_o;
   logic       ecnt;
   logic       osc;
   logic [2:0] cap;
   logic [2:0] pins;
   logic       irq_o;
   logic       wdr;
   logic       seen;
   logic [15:0] c;
   int         n_fail = 0;
   int         checks = 0;
   int         cycles = 0;
   int         hi;
   int         tg;
   int         tb[3] = '{4, 1, 0};
   int         dv[3] = '{1, 4, 12};
   int         expq[$];
   logic [15:0] v;
   always #5 clk_i = ~clk_i;
   counter_array_register_set u_counter_array_register_set (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_i(sfr_i),
      .sfr_rdata_o(sfr_rdata_o), .cpu_idle_i(cpu_idle_i),
      .timer0_ovf_i(timer0_ovf_i), .external_count_input_i(ecnt),
      .ext_osc_i(osc), .capture_pin_i(cap), .module_output_pin_o(pins),
      .irq_o(irq_o), .watchdog_reset_o(wdr));
   pin_side_model u_pin_side_model (.clk_i(clk_i), .pin_i(pins),
      .count_o(ecnt), .osc_o(osc), .cap_o(cap));
   task automatic print_verdict();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(negedge clk_i);
      sfr_i <= '{addr: a, wr: 1'b1, wdata: d};
      @(negedge clk_i);
      sfr_i.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      sfr_i.addr <= a;
      @(negedge clk_i);
      d = sfr_rdata_o;
   endtask
   task automatic chk(input logic [7:0] a, e);
      logic [7:0] d;
      rd(a, d);
      checks++;
      if (d !== e) begin
         n_fail++;
         $display("unexpected at %0t: reg %h got %h exp %h", $time, a, d, e);
      end
   endtask
   task automatic near(input logic [31:0] g, input int e, tol);
      checks++;
      if ((^g) === 1'bx || int'(g) > e + tol || int'(g) < e - tol) begin
         n_fail++;
         $display("unexpected at %0t: got %0d exp %0d", $time, g, e);
      end
   endtask
   // Restarts the counter from a value and runs it for n clocks.
   task automatic run(input logic [15:0] s, input int n);
      wr(`ADDR_CNT_LO, s[7:0]);
      wr(`ADDR_CNT_HI, s[15:8]);
      wr(`ADDR_CTRL, 8'h40);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic stop_read();
      wr(`ADDR_CTRL, 8'h00);
      rd(`ADDR_CNT_LO, c[7:0]);
      rd(`ADDR_CNT_HI, c[15:8]);
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 12000) begin
         n_fail++;
         print_verdict();
      end
   end
   initial begin
      void'($urandom(37));
      repeat (20) @(negedge clk_i);
      rst_n_i <= 1'b1;
      chk(`ADDR_CTRL, `RST_CTRL);
      chk(`ADDR_MODE, `RST_MODE);
      wr(`ADDR_MODE, 8'h48);
      chk(`ADDR_MODE, 8'h40);
      wr(`ADDR_MODE, 8'h00);
      chk(`ADDR_MODE, 8'h00);
      wr(`ADDR_CTRL, 8'h38);
      chk(`ADDR_CTRL, 8'h00);
      for (int k = 0; k < 3; k++) begin
         wr(`ADDR_MODE, 8'(tb[k] << 1));
         run(16'h0000, 240);
         stop_read();
         near(c, 241 / dv[k], 3);
         repeat (50) @(negedge clk_i);
         v = c;
         stop_read();
         near(c, int'(v), 0);
      end
      wr(`ADDR_MODE, 8'h09);
      run(16'hfff0, 40);
      chk(`ADDR_CTRL, 8'hc0);
      near(irq_o, 1, 0);
      wr(`ADDR_CTRL, 8'h40);
      @(negedge clk_i);
      near(irq_o, 0, 0);
      wr(`ADDR_MODE, 8'h08);
      wr(`ADDR_CTRL, 8'hc0);
      repeat (2) @(negedge clk_i);
      near(irq_o, 0, 0);
      wr(`ADDR_MOD0, 8'h4d);
      wr(`ADDR_CMPL0, 8'h20);
      chk(`ADDR_MOD0, 8'h0d);
      wr(`ADDR_CMPH0, 8'h00);
      chk(`ADDR_MOD0, 8'h4d);
      run(16'h0000, 60);
      chk(`ADDR_CTRL, 8'h41);
      near(pins[0], 1, 0);
      near(irq_o, 1, 0);
      wr(`ADDR_CMPL0, 8'h20);
      run(16'h0000, 60);
      chk(`ADDR_CTRL, 8'h40);
      near(pins[0], 1, 0);
      wr(`ADDR_MOD2, 8'h42);
      wr(`ADDR_CMPL2, 8'h80);
      wr(`ADDR_CMPH2, 8'h80);
      wr(`ADDR_MOD1, 8'h46);
      wr(`ADDR_CMPL1, 8'h00);
      wr(`ADDR_CMPH1, 8'h10);
      run(16'h0000, 20);
      u_pin_side_model.measure(2, 512, hi, tg);
      near(hi, 256, 4);
      u_pin_side_model.measure(1, 320, hi, tg);
      near(tg, 20, 1);
      wr(`ADDR_CTRL, 8'h00);
      for (int k = 0; k < 2; k++) begin
         v = 16'($urandom);
         expq.push_back(int'(v));
         wr(`ADDR_CNT_LO, v[7:0]);
         wr(`ADDR_CNT_HI, v[15:8]);
         wr(`ADDR_MOD1, k == 0 ? 8'h20 : 8'h10);
         u_pin_side_model.set_cap(1, k == 0);
         repeat (4) @(negedge clk_i);
         v = 16'(expq.pop_front());
         chk(`ADDR_CMPL1, v[7:0]);
         chk(`ADDR_CMPH1, v[15:8]);
         chk(`ADDR_CTRL, 8'h02);
         wr(`ADDR_CTRL, 8'h00);
      end
      wr(`ADDR_MODE, 8'h06);
      run(16'h0000, 0);
      u_pin_side_model.edges(10);
      stop_read();
      near(c, 10, 0);
      wr(`ADDR_MODE, 8'h0a);
      run(16'h0000, 0);
      u_pin_side_model.osc_run(64);
      stop_read();
      near(c, 8, 1);
      wr(`ADDR_MODE, 8'h88);
      cpu_idle_i <= 1'b1;
      run(16'h0000, 50);
      stop_read();
      near(c, 0, 0);
      cpu_idle_i <= 1'b0;
      wr(`ADDR_MODE, 8'h20);
      chk(`ADDR_MODE, 8'h60);
      wr(`ADDR_MODE, 8'h00);
      chk(`ADDR_MODE, 8'h60);
      wr(`ADDR_CTRL, 8'h04);
      seen = 1'b0;
      repeat (2) begin
         seen |= wdr;
         @(negedge clk_i);
      end
      near(seen, 1, 0);
      print_verdict();
   end
endmodule
`default_nettype wire
